/* File: pkg/sdr_pkg.sv */
package sdr_pkg;
	// Channel command codes
	localparam logic [7:0] SDR_CMD_TEST_IO = 8'h00;
	localparam logic [7:0] SDR_CMD_SENSE = 8'h04;
	localparam logic [7:0] SDR_CMD_RD_LOG = 8'hA4;
	localparam logic [7:0] SDR_CMD_RD_DIAG = 8'h44;
	localparam logic [7:0] SDR_CMD_RESERVE = 8'hB4;
	localparam logic [7:0] SDR_CMD_RELEASE = 8'h94;
	localparam logic [7:0] SDR_CMD_FILE_MASK = 8'h1F;
	localparam logic [7:0] SDR_CMD_DIAG_WRITE = 8'h05;
	localparam logic [7:0] SDR_CMD_DIAG_LOAD = 8'h0D;
	// Transfer lengths in bytes
	localparam logic [9:0] SDR_LEN_SENSE = 10'h018;
	localparam logic [9:0] SDR_LEN_ERR = 10'h010;
	localparam logic [9:0] SDR_LEN_DIAG = 10'h29C;
	localparam logic [9:0] SDR_LEN_STAT = 10'h001;
	localparam int SDR_DIAG_BYTES = 668;
	localparam int SDR_ERR_BYTES = 16;
	localparam int SDR_DRIVES = 32;
	// Sense format codes (byte 7 high nibble)
	localparam logic [3:0] SDR_FMT_NODISP = 4'h4;
	localparam logic [3:0] SDR_FMT_DISP = 4'h5;
	localparam logic [3:0] SDR_FMT_USAGE = 4'h6;
	// Command reject bit in sense byte 0
	localparam logic [7:0] SDR_SNS0_REJECT = 8'h80;
	// Register byte offsets
	localparam logic [7:0] SDR_REG_SENSE_LO = 8'h00;
	localparam logic [7:0] SDR_REG_SENSE_HI = 8'h04;
	localparam logic [7:0] SDR_REG_SEEK = 8'h08;
	localparam logic [7:0] SDR_REG_RECORD = 8'h0C;
	localparam logic [7:0] SDR_REG_SOURCE = 8'h10;
	localparam logic [7:0] SDR_REG_RESTART = 8'h14;
	localparam logic [7:0] SDR_REG_ERR_DISP = 8'h18;
	localparam logic [7:0] SDR_REG_PATTERN = 8'h1C;
	localparam logic [7:0] SDR_REG_STATUS = 8'h20;

	typedef enum logic [1:0] {
		SDR_ST_IDLE = 2'b00,
		SDR_ST_SEND = 2'b01,
		SDR_ST_LOAD = 2'b10
	} sdr_state_e;

	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [1:0] chan;
		logic [4:0] drive;
		logic chain_first;
	} sdr_cmd_s;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
	} sdr_byte_s;

	typedef struct packed {
		logic valid;
		logic ce;
		logic de;
		logic uc;
		logic busy;
		logic [4:0] drive;
	} sdr_end_s;

	typedef struct packed {
		logic bytes_read;
		logic corr;
		logic uncorr;
		logic seek;
		logic seek_err;
		logic [3:0] cmd_ovr;
		logic [3:0] dat_ovr;
	} sdr_evt_s;

	typedef struct packed {
		logic done;
		logic fail;
		logic [15:0][7:0] code;
	} sdr_test_s;

	typedef struct packed {
		logic valid;
		logic [7:0] stat;
	} sdr_pend_s;
endpackage : sdr_pkg

/* File: design/sdr_cmd.sv */
`timescale 1ns/100ps
module sdr_cmd
	import sdr_pkg::*;
(
	input wire logic i_ref_clk, // System clock
	input wire logic i_rst_b, // Async reset, active low
	input wire logic i_sys_reset, // Channel system reset pulse
	input wire sdr_cmd_s i_cmd, // Command from channel
	output logic o_cmd_ready, // Ready for a command
	output sdr_byte_s o_dat, // Data bytes to channel
	input wire logic i_dat_ready, // Channel takes a byte
	input wire sdr_byte_s i_wr, // Diagnostic bytes from channel
	output logic o_wr_ready, // Diagnostic byte accepted
	output sdr_end_s o_end, // Ending status pulse
	input wire logic [31:0] i_drive_busy, // Normal busy per drive
	input wire sdr_pend_s i_pend, // Stacked or pending status
	input wire sdr_evt_s i_evt, // Usage and error events
	output logic o_test_run, // Transient test running
	output logic [4:0] o_test_drive, // Drive under test
	input wire sdr_test_s i_test, // Test completion
	output logic [31:0] o_resv, // Reserved drive flags
	input wire logic [7:0] i_addr, // Register byte address
	input wire logic [31:0] i_wdata, // Register write data
	input wire logic i_we, // Register write strobe
	input wire logic i_re, // Register read strobe
	output logic [31:0] o_rdata // Read data, one cycle later
);
	// Complete state of the block
	typedef struct packed {
		sdr_state_e st;
		logic [7:0] code;
		logic [4:0] drive;
		logic [9:0] idx;
		logic [9:0] len;
		logic [1:0] src;
		sdr_byte_s dat;
		sdr_end_s fin;
		logic wr_rdy;
		logic cmd_rdy;
		logic [31:0] rdata;
		logic [7:0][7:0] sns;
		logic [31:0] seek;
		logic [31:0] rec;
		logic [31:0] source;
		logic [23:0] restart;
		logic [15:0] err_disp;
		logic [23:0] pattern;
		logic reject;
		logic file_mask;
		logic [31:0] resv;
		logic [31:0][1:0] owner;
		logic [1:0] last_diag;
		logic test_run;
		logic test_pend;
		logic [4:0] test_drive;
		logic [SDR_DIAG_BYTES-1:0][7:0] diag;
		logic [SDR_ERR_BYTES-1:0][7:0] err;
		logic [31:0] cnt_read;
		logic [15:0] cnt_corr;
		logic [15:0] cnt_uncorr;
		logic [15:0] cnt_seek;
		logic [7:0] cnt_seek_err;
		logic [3:0][7:0] cnt_cmd_ovr;
		logic [3:0][7:0] cnt_dat_ovr;
		logic log_avail;
		logic [7:0] pend;
	} sdr_all_s;

	sdr_all_s s_reg; // Registered state
	sdr_all_s s_next; // Next state

	// Byte sources for transfers
	localparam logic [1:0] SRC_SENSE = 2'b00;
	localparam logic [1:0] SRC_LOG = 2'b01;
	localparam logic [1:0] SRC_STAT = 2'b10;
	localparam logic [1:0] SRC_DIAG = 2'b11;
	// Last diagnostic command that filled the buffer
	localparam logic [1:0] DIAG_NONE = 2'b00;
	localparam logic [1:0] DIAG_WROTE = 2'b01;
	localparam logic [1:0] DIAG_LOADED = 2'b10;

	// Sense byte at index, laid out by format code
	function automatic logic [7:0] sense_at(sdr_all_s s, logic [9:0] i, logic [3:0] f);
		logic [7:0] b;
		logic sel;
		b = 8'h00;
		sel = s.source[15];
		if (i < 10'h008) begin
			b = s.sns[3'(i)];
			if (i == 10'h000 && s.reject) begin
				b = b | SDR_SNS0_REJECT;
			end
			if (i == 10'h007) begin
				b = {f, s.sns[7][3:0]};
			end
		end else if (f == SDR_FMT_NODISP || f == SDR_FMT_DISP) begin
			case (i)
				10'h008: b = s.seek[31:24];
				10'h009: b = s.seek[23:16];
				10'h00A: b = s.seek[15:8];
				10'h00B: b = s.seek[7:0];
				10'h00C: b = s.rec[31:24];
				10'h00D: b = s.rec[23:16];
				10'h00E: b = s.rec[15:8];
				10'h00F: b = (f == SDR_FMT_NODISP) ? s.rec[7:0] : s.restart[23:16];
				10'h010: b = (f == SDR_FMT_NODISP) ? s.source[7:0] : s.restart[15:8];
				10'h011: b = (f == SDR_FMT_NODISP) ? 8'h00 : s.restart[7:0];
				10'h012: b = (f == SDR_FMT_NODISP) ? 8'h00 : s.err_disp[15:8];
				10'h013: b = (f == SDR_FMT_NODISP) ? 8'h00 : s.err_disp[7:0];
				10'h014: b = (f == SDR_FMT_NODISP) ? 8'h00 : s.pattern[23:16];
				10'h015: b = (f == SDR_FMT_NODISP) ? 8'h00 : s.pattern[15:8];
				10'h016: b = (f == SDR_FMT_NODISP) ? s.source[31:24] : s.pattern[7:0];
				10'h017: b = (f == SDR_FMT_NODISP) ? s.source[23:16] : {7'h00, s.source[8]};
				default: b = 8'h00;
			endcase
		end else if (f == SDR_FMT_USAGE) begin
			case (i)
				10'h008: b = s.cnt_read[31:24];
				10'h009: b = s.cnt_read[23:16];
				10'h00A: b = s.cnt_read[15:8];
				10'h00B: b = s.cnt_read[7:0];
				10'h00C: b = s.cnt_corr[15:8];
				10'h00D: b = s.cnt_corr[7:0];
				10'h00E: b = s.cnt_uncorr[15:8];
				10'h00F: b = s.cnt_uncorr[7:0];
				10'h010: b = s.cnt_seek[15:8];
				10'h011: b = s.cnt_seek[7:0];
				10'h012: b = {sel, 7'h00};
				10'h013: b = s.cnt_seek_err;
				10'h014: b = s.cnt_cmd_ovr[sel ? 2 : 0];
				10'h015: b = s.cnt_dat_ovr[sel ? 2 : 0];
				10'h016: b = s.cnt_cmd_ovr[sel ? 3 : 1];
				10'h017: b = s.cnt_dat_ovr[sel ? 3 : 1];
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction : sense_at

	// Saturating increment helpers
	function automatic logic [31:0] sat32(logic [31:0] c, logic inc);
		return (inc && c != 32'hFFFF_FFFF) ? c + 32'h0000_0001 : c;
	endfunction : sat32

	function automatic logic [15:0] sat16(logic [15:0] c, logic inc);
		return (inc && c != 16'hFFFF) ? c + 16'h0001 : c;
	endfunction : sat16

	function automatic logic [7:0] sat8(logic [7:0] c, logic inc);
		return (inc && c != 8'hFF) ? c + 8'h01 : c;
	endfunction : sat8

	// Next-state logic
	always_comb begin
		logic busy;
		logic clr;
		logic full;
		logic [7:0] nb;
		busy = 1'b0;
		clr = 1'b0;
		full = 1'b0;
		nb = 8'h00;
		s_next = s_reg;
		s_next.fin = '0;
		s_next.rdata = 32'h0000_0000;
		// Register writes from software
		if (i_we) begin
			case (i_addr)
				SDR_REG_SENSE_LO: s_next.sns[3:0] = {i_wdata[7:0], i_wdata[15:8],
					i_wdata[23:16], i_wdata[31:24]};
				SDR_REG_SENSE_HI: s_next.sns[7:4] = {i_wdata[7:0], i_wdata[15:8],
					i_wdata[23:16], i_wdata[31:24]};
				SDR_REG_SEEK: s_next.seek = i_wdata;
				SDR_REG_RECORD: s_next.rec = i_wdata;
				SDR_REG_SOURCE: s_next.source = i_wdata;
				SDR_REG_RESTART: s_next.restart = i_wdata[23:0];
				SDR_REG_ERR_DISP: s_next.err_disp = i_wdata[15:0];
				SDR_REG_PATTERN: s_next.pattern = i_wdata[23:0];
				default: s_next.rec = s_reg.rec; // Unmapped write ignored
			endcase
		end
		// Register reads, data stands one cycle
		if (i_re) begin
			case (i_addr)
				SDR_REG_SENSE_LO: s_next.rdata = {s_reg.sns[0], s_reg.sns[1],
					s_reg.sns[2], s_reg.sns[3]};
				SDR_REG_SENSE_HI: s_next.rdata = {s_reg.sns[4], s_reg.sns[5],
					s_reg.sns[6], s_reg.sns[7]};
				SDR_REG_SEEK: s_next.rdata = s_reg.seek;
				SDR_REG_RECORD: s_next.rdata = s_reg.rec;
				SDR_REG_SOURCE: s_next.rdata = s_reg.source;
				SDR_REG_RESTART: s_next.rdata = {8'h00, s_reg.restart};
				SDR_REG_ERR_DISP: s_next.rdata = {16'h0000, s_reg.err_disp};
				SDR_REG_PATTERN: s_next.rdata = {8'h00, s_reg.pattern};
				SDR_REG_STATUS: s_next.rdata = {22'h00_0000, s_reg.test_drive,
					s_reg.last_diag, s_reg.test_run, s_reg.reject, s_reg.log_avail};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
		// Test completion, held until it can be reported
		if (s_reg.test_run && i_test.done) begin
			s_next.test_run = 1'b0;
			s_next.test_pend = 1'b1;
			if (i_test.fail) begin
				s_next.err = i_test.code;
			end
		end
		case (s_reg.st)
			SDR_ST_IDLE: begin
				if (i_cmd.valid && s_reg.cmd_rdy) begin
					s_next.cmd_rdy = 1'b0;
					s_next.code = i_cmd.code;
					s_next.drive = i_cmd.drive;
					s_next.idx = 10'h000;
					s_next.len = SDR_LEN_SENSE;
					s_next.src = SRC_SENSE;
					s_next.st = SDR_ST_SEND;
					if (i_cmd.chain_first) begin
						s_next.file_mask = 1'b0;
					end
					busy = i_drive_busy[i_cmd.drive] ||
						(s_reg.test_run && s_reg.test_drive == i_cmd.drive) ||
						(s_reg.resv[i_cmd.drive] && s_reg.owner[i_cmd.drive] != i_cmd.chan);
					case (i_cmd.code)
						SDR_CMD_SENSE: s_next.src = SRC_SENSE;
						SDR_CMD_RD_LOG: s_next.src = SRC_LOG;
						SDR_CMD_TEST_IO: begin
							s_next.src = SRC_STAT;
							s_next.len = SDR_LEN_STAT;
							s_next.pend = i_pend.valid ? i_pend.stat : 8'h00;
						end
						SDR_CMD_RD_DIAG: begin
							s_next.src = SRC_DIAG;
							s_next.len = (s_reg.last_diag == DIAG_LOADED) ? SDR_LEN_DIAG
								: SDR_LEN_ERR;
						end
						SDR_CMD_DIAG_WRITE, SDR_CMD_DIAG_LOAD: begin
							s_next.st = SDR_ST_LOAD;
							s_next.wr_rdy = 1'b1;
						end
						SDR_CMD_FILE_MASK: begin
							s_next.file_mask = 1'b1;
							s_next.st = SDR_ST_IDLE;
							s_next.cmd_rdy = 1'b1;
							s_next.fin = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, i_cmd.drive};
						end
						SDR_CMD_RESERVE, SDR_CMD_RELEASE: begin
							// Unsafe or offline state is not consulted here
							if (s_reg.file_mask && !i_cmd.chain_first) begin
								s_next.reject = 1'b1;
								s_next.st = SDR_ST_IDLE;
								s_next.cmd_rdy = 1'b1;
								s_next.fin = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, i_cmd.drive};
							end else if (busy) begin
								s_next.st = SDR_ST_IDLE;
								s_next.cmd_rdy = 1'b1;
								s_next.fin = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, i_cmd.drive};
							end else if (i_cmd.code == SDR_CMD_RESERVE) begin
								s_next.resv[i_cmd.drive] = 1'b1;
								s_next.owner[i_cmd.drive] = i_cmd.chan;
							end else begin
								s_next.resv[i_cmd.drive] = 1'b0;
							end
						end
						default: begin
							s_next.reject = 1'b1;
							s_next.st = SDR_ST_IDLE;
							s_next.cmd_rdy = 1'b1;
							s_next.fin = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, i_cmd.drive};
						end
					endcase
				end else if (s_reg.test_pend) begin
					s_next.test_pend = 1'b0;
					s_next.fin = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, s_reg.test_drive};
				end
			end
			SDR_ST_SEND: begin
				// Byte stream with channel back-pressure
				if (!s_reg.dat.valid || i_dat_ready) begin
					if (s_reg.idx == s_reg.len) begin
						s_next.dat = '0;
						s_next.st = SDR_ST_IDLE;
						s_next.cmd_rdy = 1'b1;
						s_next.fin = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, s_reg.drive};
						if (s_reg.src == SRC_SENSE) begin
							s_next.reject = 1'b0;
						end
						clr = (s_reg.src == SRC_LOG);
					end else begin
						case (s_reg.src)
							SRC_SENSE: nb = sense_at(s_reg, s_reg.idx, s_reg.sns[7][7:4]);
							SRC_LOG: nb = sense_at(s_reg, s_reg.idx, SDR_FMT_USAGE);
							SRC_STAT: nb = s_reg.pend;
							default: nb = (s_reg.len == SDR_LEN_DIAG) ? s_reg.diag[s_reg.idx]
								: s_reg.err[s_reg.idx[3:0]];
						endcase
						s_next.dat = '{1'b1, nb, s_reg.idx == s_reg.len - 10'h001};
						s_next.idx = s_reg.idx + 10'h001;
					end
				end
			end
			SDR_ST_LOAD: begin
				// Diagnostic bytes into buffer storage
				if (i_wr.valid && s_reg.wr_rdy) begin
					s_next.diag[s_reg.idx] = i_wr.data;
					s_next.idx = s_reg.idx + 10'h001;
					full = (s_reg.idx == SDR_LEN_DIAG - 10'h001);
					if (full || i_wr.last) begin
						s_next.wr_rdy = 1'b0;
						s_next.st = SDR_ST_IDLE;
						s_next.cmd_rdy = 1'b1;
						if (!full) begin
							s_next.fin = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, s_reg.drive};
						end else if (s_reg.code == SDR_CMD_DIAG_WRITE) begin
							s_next.last_diag = DIAG_WROTE;
							s_next.test_run = 1'b1;
							s_next.test_drive = s_reg.drive;
							s_next.fin = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, s_reg.drive};
						end else begin
							s_next.last_diag = DIAG_LOADED;
							s_next.fin = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, s_reg.drive};
						end
					end
				end
			end
			default: s_next.st = SDR_ST_IDLE;
		endcase
		// System reset drops every reservation
		if (i_sys_reset) begin
			s_next.resv = 32'h0000_0000;
		end
		// Usage and error counters, cleared then counted
		if (clr) begin
			s_next.cnt_read = 32'h0000_0000;
			s_next.cnt_corr = 16'h0000;
			s_next.cnt_uncorr = 16'h0000;
			s_next.cnt_seek = 16'h0000;
			s_next.cnt_seek_err = 8'h00;
			s_next.cnt_cmd_ovr = '0;
			s_next.cnt_dat_ovr = '0;
			s_next.log_avail = 1'b0;
		end
		s_next.cnt_read = sat32(s_next.cnt_read, i_evt.bytes_read);
		s_next.cnt_corr = sat16(s_next.cnt_corr, i_evt.corr);
		s_next.cnt_uncorr = sat16(s_next.cnt_uncorr, i_evt.uncorr);
		s_next.cnt_seek = sat16(s_next.cnt_seek, i_evt.seek);
		s_next.cnt_seek_err = sat8(s_next.cnt_seek_err, i_evt.seek_err);
		for (int c = 0; c < 4; c++) begin
			s_next.cnt_cmd_ovr[c] = sat8(s_next.cnt_cmd_ovr[c], i_evt.cmd_ovr[c]);
			s_next.cnt_dat_ovr[c] = sat8(s_next.cnt_dat_ovr[c], i_evt.dat_ovr[c]);
			if (s_next.cnt_cmd_ovr[c] == 8'hFF || s_next.cnt_dat_ovr[c] == 8'hFF) begin
				s_next.log_avail = 1'b1;
			end
		end
		if (s_next.cnt_read == 32'hFFFF_FFFF || s_next.cnt_corr == 16'hFFFF ||
			s_next.cnt_uncorr == 16'hFFFF || s_next.cnt_seek == 16'hFFFF ||
			s_next.cnt_seek_err == 8'hFF) begin
			s_next.log_avail = 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_reg <= '0;
			s_reg.cmd_rdy <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from state flops
	assign o_cmd_ready = s_reg.cmd_rdy;
	assign o_dat = s_reg.dat;
	assign o_wr_ready = s_reg.wr_rdy;
	assign o_end = s_reg.fin;
	assign o_test_run = s_reg.test_run;
	assign o_test_drive = s_reg.test_drive;
	assign o_resv = s_reg.resv;
	assign o_rdata = s_reg.rdata;
endmodule : sdr_cmd

/* File: test/sdr_cmd_asserts.sv */
`timescale 1ns/100ps
module sdr_cmd_asserts
	import sdr_pkg::*;
(
	input wire logic i_ref_clk, // Clock
	input wire logic i_rst_b, // Reset, active low
	input wire logic i_sys_reset, // System reset
	input wire sdr_cmd_s i_cmd, // Command
	input wire logic o_cmd_ready, // Command ready
	input wire sdr_byte_s o_dat, // Bytes out
	input wire logic i_dat_ready, // Byte taken
	input wire sdr_byte_s i_wr, // Bytes in
	input wire logic o_wr_ready, // Byte accepted
	input wire sdr_end_s o_end, // Ending status
	input wire logic [31:0] i_drive_busy, // Busy drives
	input wire sdr_pend_s i_pend, // Pending status
	input wire logic o_test_run, // Test running
	input wire sdr_test_s i_test, // Test result
	input wire logic [31:0] o_resv, // Reservations
	input wire logic i_re, // Read strobe
	input wire logic [31:0] o_rdata // Read data
);
	// One clock domain for all checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	logic take; // Command taken at this edge
	assign take = i_cmd.valid && o_cmd_ready;
	a_end_pulse: assert property (o_end.valid |=> !o_end.valid)
		else $error("ending status held beyond one cycle");
	a_read_idle: assert property (!i_re |=> o_rdata == 32'h0000_0000)
		else $error("read data not zero outside read cycle");
	a_dat_hold: assert property (o_dat.valid && !i_dat_ready |=> o_dat.valid && $stable(o_dat))
		else $error("byte changed before the channel took it");
	// First byte leaves one cycle after the sending state is entered
	a_sense_start: assert property (take && i_cmd.code == SDR_CMD_SENSE |=>
		!o_cmd_ready && !o_dat.valid ##1 o_dat.valid)
		else $error("sense did not start sending");
	a_testio_byte: assert property (take && i_cmd.code == SDR_CMD_TEST_IO |=> ##1
		o_dat.valid && o_dat.last &&
		o_dat.data == ($past(i_pend.valid, 2) ? $past(i_pend.stat, 2) : 8'h00))
		else $error("status byte wrong");
	a_busy_reject: assert property (take && i_cmd.chain_first &&
		(i_cmd.code == SDR_CMD_RESERVE || i_cmd.code == SDR_CMD_RELEASE) &&
		i_drive_busy[i_cmd.drive] |=> o_end.valid && o_end.busy)
		else $error("busy drive not rejected");
	a_last_end: assert property (o_dat.valid && o_dat.last && i_dat_ready |=>
		o_end.valid && o_end.ce && o_end.de)
		else $error("no channel and device end after last byte");
	a_sys_clear: assert property (i_sys_reset |=> o_resv == 32'h0000_0000)
		else $error("system reset left a reservation");
	a_wr_close: assert property (i_wr.valid && o_wr_ready && i_wr.last |=>
		!o_wr_ready && o_end.valid)
		else $error("diagnostic stream not closed");
	a_test_de: assert property (o_test_run && i_test.done |=>
		!o_test_run ##[0:999] (o_end.valid && o_end.de && !o_end.ce))
		else $error("no device end after test");
	// Main scenarios reached
	c_sense: cover property (take && i_cmd.code == SDR_CMD_SENSE);
	c_busy: cover property (o_end.valid && o_end.busy);
	c_test: cover property (o_test_run && i_test.done);
endmodule : sdr_cmd_asserts
bind sdr_cmd sdr_cmd_asserts chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
	.i_sys_reset(i_sys_reset), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_dat(o_dat),
	.i_dat_ready(i_dat_ready), .i_wr(i_wr), .o_wr_ready(o_wr_ready), .o_end(o_end),
	.i_drive_busy(i_drive_busy), .i_pend(i_pend), .o_test_run(o_test_run),
	.i_test(i_test), .o_resv(o_resv), .i_re(i_re), .o_rdata(o_rdata));

/* File: test/sdr_chan_model.sv */
`timescale 1ns/100ps
module sdr_chan_model
	import sdr_pkg::*;
(
	input wire logic i_ref_clk, // Clock
	input wire logic i_rst_b, // Reset, active low
	input wire logic i_slow, // Stall every other cycle
	input wire logic i_go, // Start a diagnostic stream
	input wire logic [9:0] i_len, // Stream length in bytes
	input wire logic i_wr_ready, // Device took a byte
	output logic o_dat_ready, // Channel takes a byte
	output sdr_byte_s o_wr // Diagnostic bytes out
);
	logic [9:0] cnt; // Bytes still to send
	logic [9:0] idx; // Index of the byte offered
	// Take bytes each cycle or every other one
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_dat_ready <= 1'b0;
		end else begin
			o_dat_ready <= i_slow ? !o_dat_ready : 1'b1;
		end
	end
	// Step only when the device took the byte
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= 10'h000;
			idx <= 10'h000;
		end else if (i_go) begin
			cnt <= i_len;
			idx <= 10'h000;
		end else if (o_wr.valid && i_wr_ready) begin
			cnt <= cnt - 10'h001;
			idx <= idx + 10'h001;
		end
	end
	// Byte pattern; released line shows inverse of last byte
	always_comb begin
		o_wr.valid = cnt != 10'h000;
		o_wr.last = cnt == 10'h001;
		if (o_wr.valid) begin
			o_wr.data = idx[7:0] ^ 8'h5A;
		end else begin
			o_wr.data = ~((idx[7:0] - 8'h01) ^ 8'h5A);
		end
	end
endmodule : sdr_chan_model

/* File: test/sdr_cmd_tb.sv */
`timescale 1ns/100ps
module sdr_cmd_tb;
	import sdr_pkg::*;
	logic clk, rst_b, sys_rst, cmd_rdy, dat_rdy, wr_rdy, run_t, we, re, slow, go;
	sdr_cmd_s cmd; // Command to device
	sdr_byte_s dat, wr; // Byte streams
	sdr_end_s endp, endv; // Ending status and last seen
	sdr_pend_s pend; // Pending status
	sdr_evt_s evt; // Counter events
	sdr_test_s tst; // Test result
	logic [31:0] busy, resv, wdata, rdata, d;
	logic [7:0] addr;
	logic [4:0] tdrv;
	logic [9:0] len;
	logic [1:0] ch; // Issuing channel
	logic [7:0] got [668]; // Bytes seen by the channel
	int nb, errors, compares, k;
	sdr_cmd uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_sys_reset(sys_rst), .i_cmd(cmd),
		.o_cmd_ready(cmd_rdy), .o_dat(dat), .i_dat_ready(dat_rdy), .i_wr(wr),
		.o_wr_ready(wr_rdy), .o_end(endp), .i_drive_busy(busy), .i_pend(pend),
		.i_evt(evt), .o_test_run(run_t), .o_test_drive(tdrv), .i_test(tst),
		.o_resv(resv), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
		.o_rdata(rdata));
	sdr_chan_model chan (.i_ref_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_go(go),
		.i_len(len), .i_wr_ready(wr_rdy), .o_dat_ready(dat_rdy), .o_wr(wr));
	always #4 clk = ~clk;
	// Capture bytes and ending status mid-cycle
	always @(negedge clk) begin
		if (dat.valid && dat_rdy && nb < 668) got[nb] = dat.data;
		if (dat.valid && dat_rdy) nb++;
		if (endp.valid) endv = endp;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Issue one command, optionally start a stream, await end
	task automatic run(input logic [7:0] c, input logic [4:0] dr, input logic f,
		input logic [9:0] l);
		int n;
		@(posedge clk);
		nb = 0;
		endv = '0;
		cmd <= '{1'b1, c, ch, dr, f};
		go <= l != 10'h000;
		len <= l;
		@(posedge clk);
		cmd.valid <= 1'b0;
		go <= 1'b0;
		for (n = 0; n < 4000 && !endv.valid; n++) @(posedge clk);
		if (!endv.valid) errors++; // Ending status never came
		#1;
	endtask : run
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		re <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		we <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr_reg
	task automatic pulse(input sdr_evt_s e, input int n);
		repeat (n) begin
			@(posedge clk);
			evt <= e;
			@(posedge clk);
			evt <= '0;
		end
	endtask : pulse
	task automatic finish_test();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// Cut a hang short
	initial begin
		#400000;
		errors++;
		finish_test();
	end
	initial begin
		{clk, rst_b, sys_rst, we, re, slow, go, busy, wdata, addr, len} = '0;
		{cmd, pend, evt, tst, endv} = '0;
		{errors, compares, nb} = '0;
		ch = 2'd1;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		chk(cmd_rdy, 1'b1);
		chk(resv, 32'h0000_0000);
		rd(8'hFC);
		chk(d, 32'h0000_0000);
		rd(SDR_REG_STATUS);
		chk(d, 32'h0000_0000);
		wr_reg(SDR_REG_STATUS, 32'hFFFF_FFFF);
		wr_reg(8'hFC, 32'hFFFF_FFFF);
		rd(SDR_REG_STATUS);
		chk(d, 32'h0000_0000);
		$display("test reset done");
		slow = 1'b1;
		run(SDR_CMD_SENSE, 5'd2, 1'b1, 10'h000);
		chk(nb, 24);
		chk({endv.ce, endv.de, endv.uc}, 3'b110);
		pend <= '{1'b1, 8'h0C};
		run(SDR_CMD_TEST_IO, 5'd2, 1'b1, 10'h000);
		chk({nb[7:0], got[0]}, 16'h010C);
		pend <= '0;
		run(SDR_CMD_TEST_IO, 5'd2, 1'b1, 10'h000);
		chk({nb[7:0], got[0]}, 16'h0100);
		$display("test sense done");
		run(SDR_CMD_RESERVE, 5'd3, 1'b1, 10'h000);
		chk({nb[7:0], resv[3]}, 9'h031);
		ch = 2'd2;
		run(SDR_CMD_RESERVE, 5'd3, 1'b1, 10'h000);
		chk({endv.busy, resv[3]}, 2'b11);
		ch = 2'd1;
		busy[5] <= 1'b1;
		run(SDR_CMD_RELEASE, 5'd5, 1'b1, 10'h000);
		chk({nb[7:0], endv.busy}, 9'h001);
		busy <= '0;
		run(SDR_CMD_RELEASE, 5'd3, 1'b1, 10'h000);
		chk({nb[7:0], resv[3]}, 9'h030);
		run(SDR_CMD_RESERVE, 5'd4, 1'b1, 10'h000);
		chk(resv[4], 1'b1);
		@(posedge clk);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		#1 chk(resv, 32'h0000_0000);
		for (k = 0; k < 2; k++) begin
			run(SDR_CMD_FILE_MASK, 5'd6, 1'b1, 10'h000);
			run(k ? SDR_CMD_RELEASE : SDR_CMD_RESERVE, 5'd6, 1'b0, 10'h000);
			chk({endv.ce, endv.de, endv.uc, resv[6]}, 4'b1110);
			rd(SDR_REG_STATUS);
			chk(d[1], 1'b1);
			run(SDR_CMD_SENSE, 5'd6, 1'b1, 10'h000);
			chk(got[0] & SDR_SNS0_REJECT, SDR_SNS0_REJECT);
		end
		$display("test reserve done");
		run(SDR_CMD_RD_DIAG, 5'd7, 1'b1, 10'h000);
		chk(nb, 16);
		run(SDR_CMD_DIAG_LOAD, 5'd7, 1'b1, 10'h00A);
		chk({endv.ce, endv.de, endv.uc}, 3'b111);
		run(SDR_CMD_DIAG_LOAD, 5'd7, 1'b1, SDR_LEN_DIAG);
		chk({endv.ce, endv.de, endv.uc}, 3'b110);
		rd(SDR_REG_STATUS);
		chk(d[4:3], 2'd2);
		run(SDR_CMD_RD_DIAG, 5'd7, 1'b1, 10'h000);
		chk(nb, SDR_DIAG_BYTES);
		for (k = 0; k < 668; k++) chk(got[k], k[7:0] ^ 8'h5A);
		run(SDR_CMD_DIAG_WRITE, 5'd7, 1'b1, SDR_LEN_DIAG);
		chk({endv.ce, endv.de, run_t, tdrv}, 8'hA7);
		run(SDR_CMD_SENSE, 5'd2, 1'b1, 10'h000);
		chk({nb[7:0], run_t}, 9'h031);
		for (k = 0; k < 16; k++) tst.code[k] <= 8'hC0 + k[7:0];
		tst.fail <= 1'b1;
		tst.done <= 1'b1;
		endv = '0;
		@(posedge clk);
		tst.done <= 1'b0;
		for (k = 0; k < 50 && !endv.valid; k++) @(posedge clk);
		#1 chk({endv.ce, endv.de, run_t}, 3'b010);
		run(SDR_CMD_RD_DIAG, 5'd7, 1'b1, 10'h000);
		chk(nb, SDR_ERR_BYTES);
		for (k = 0; k < 16; k++) chk(got[k], 8'hC0 + k[7:0]);
		$display("test diagnostic done");
		pulse('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 4'h0}, 3);
		pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0}, 260);
		pulse('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h2}, 2);
		rd(SDR_REG_STATUS);
		chk(d[0], 1'b1);
		run(SDR_CMD_RD_LOG, 5'd2, 1'b1, 10'h000);
		chk({nb[7:0], got[7][7:4]}, {8'h18, SDR_FMT_USAGE});
		chk({got[8], got[9], got[10], got[11]}, 32'h0000_0002);
		chk({got[16], got[17], got[19]}, 24'h00_03FF);
		chk({got[20], got[23]}, 16'h0202);
		rd(SDR_REG_STATUS);
		chk(d[0], 1'b0);
		pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4, 4'h8}, 1);
		wr_reg(SDR_REG_SEEK, 32'h1234_5678);
		wr_reg(SDR_REG_RECORD, 32'h9ABC_DEF0);
		wr_reg(SDR_REG_SOURCE, 32'hA5C3_81B7);
		wr_reg(SDR_REG_SENSE_HI, 32'h0000_0040);
		rd(SDR_REG_SEEK);
		chk(d, 32'h1234_5678);
		run(SDR_CMD_SENSE, 5'd2, 1'b1, 10'h000);
		chk({got[7], got[8], got[9], got[10]}, 32'h4012_3456);
		chk({got[11], got[12], got[13], got[14]}, 32'h789A_BCDE);
		chk({got[15], got[16], got[22], got[23]}, 32'hF0B7_A5C3);
		chk({got[17] | got[18], got[19], got[20], got[21]}, 32'h0000_0000);
		wr_reg(SDR_REG_SENSE_HI, 32'h0000_0050);
		wr_reg(SDR_REG_RESTART, 32'h0011_2233);
		wr_reg(SDR_REG_ERR_DISP, 32'h0000_4455);
		wr_reg(SDR_REG_PATTERN, 32'h0066_7788);
		run(SDR_CMD_SENSE, 5'd2, 1'b1, 10'h000);
		chk({got[15], got[16], got[17], got[18]}, 32'h1122_3344);
		chk({got[19], got[20], got[21], got[22]}, 32'h5566_7788);
		chk({got[7], got[23]}, 16'h5001);
		$display("test format done");
		run(SDR_CMD_RD_LOG, 5'd2, 1'b1, 10'h000);
		chk({got[17], got[19]}, 16'h0000);
		chk({got[18], got[20], got[23]}, 24'h80_0101);
		$display("test log done");
		finish_test();
	end
endmodule : sdr_cmd_tb
